// [rtl/dcc_defines.vh]
// Constants for the DAC channel calibration register bank
// How it works
// - Dual supply: offset codes power up trimmed
// - Separate trims per group and gain
// - Single supply: offset writes dropped, reads zero
// - Gain change reloads that group's trim
// - Doze bit D15 set sleeps serial port
// - Reset or low resume clears doze
// - Sleep routes serial input straight out
// - Broadcast at 07h loads all channels
// - Broadcast ignored while correction enabled
// - Broadcast reads back as zero
// - Correction on: input register, else data
// - Output changes only on latch transfer
// - Input data registers reset to zero
// - Code in D15:D2, D1:D0 ignored
// - Zero trim signed, resets zero
// - Gain code 0.5 to 1.5 straight binary
// - Gain trims reset to unity 2000h
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH
`define DCC_FRAME_BITS 5'h18
`define DCC_RD_BIT 23
`define DCC_ADDR_HI 20
`define DCC_ADDR_LO 16
`define DCC_ADDR_OFS_A 5'h04
`define DCC_ADDR_OFS_B 5'h05
`define DCC_ADDR_DOZE 5'h06
`define DCC_ADDR_BCAST 5'h07
`define DCC_ADDR_GRP_INPUT 2'h1
`define DCC_ADDR_GRP_ZERO 2'h2
`define DCC_ADDR_GRP_GAIN 2'h3
`define DCC_DOZE_BIT 15
`define DCC_FIELD_HI 15
`define DCC_FIELD_LO 2
`define DCC_RST_INPUT 14'h0000
`define DCC_RST_ZERO 14'h0000
`define DCC_RST_GAIN 14'h2000
`define DCC_RST_OFS 14'h0000
`define DCC_TRIM_G6 14'h2666
`define DCC_TRIM_G4 14'h2aab
`define DCC_GAIN_HALF 15'h2000
`define DCC_GAIN_SHIFT 14
`define DCC_CODE_MAX 14'h3fff
`endif

// [rtl/dcc_regs.v]
// Calibration and data register bank with serial port and correction engine
`timescale 1ns/1ns
`default_nettype none
`include "dcc_defines.vh"

module dcc_regs #(
  parameter NCH = 8,
  parameter [13:0] TRIM_A_G6 = `DCC_TRIM_G6,
  parameter [13:0] TRIM_A_G4 = `DCC_TRIM_G4,
  parameter [13:0] TRIM_B_G6 = `DCC_TRIM_G6,
  parameter [13:0] TRIM_B_G4 = `DCC_TRIM_G4
) (
  input wire clock,
  input wire nrst,
  input wire sclk,
  input wire cs_n,
  input wire sdi,
  output reg sdo,
  output reg sdo_oe,
  input wire resume_pin_n,
  input wire latch_load_n,
  input wire correction_engine_enable,
  input wire gain_sel_a,
  input wire gain_sel_b,
  input wire dual_supply,
  output reg doze_active,
  output reg [13:0] offset_a_code,
  output reg [13:0] offset_b_code,
  output reg [14*NCH-1:0] dac_latch_codes
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg [1:0] sclk_sync_reg;
reg [1:0] cs_sync_reg;
reg [1:0] sdi_sync_reg;
reg [1:0] resume_sync_reg;
reg [1:0] load_sync_reg;
reg sclk_prev_reg;
reg cs_prev_reg;
reg load_prev_reg;

always @(posedge clock or negedge nrst)
begin
  if (!nrst)
  begin
    // Serial clock idles high; a low reset value would fake a rising edge
    sclk_sync_reg <= 2'h3;
    cs_sync_reg <= 2'h3;
    sdi_sync_reg <= 2'h0;
    resume_sync_reg <= 2'h3;
    load_sync_reg <= 2'h3;
    sclk_prev_reg <= 1'b1;
    cs_prev_reg <= 1'b1;
    load_prev_reg <= 1'b1;
  end
  else
  begin
    sclk_sync_reg <= {sclk_sync_reg[0], sclk};
    cs_sync_reg <= {cs_sync_reg[0], cs_n};
    sdi_sync_reg <= {sdi_sync_reg[0], sdi};
    resume_sync_reg <= {resume_sync_reg[0], resume_pin_n};
    load_sync_reg <= {load_sync_reg[0], latch_load_n};
    sclk_prev_reg <= sclk_sync_reg[1];
    cs_prev_reg <= cs_sync_reg[1];
    load_prev_reg <= load_sync_reg[1];
  end
end

wire sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
wire sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;
wire cs_low = ~cs_sync_reg[1];
wire cs_fall = ~cs_sync_reg[1] & cs_prev_reg;
wire cs_rise = cs_sync_reg[1] & ~cs_prev_reg;
wire load_fall = ~load_sync_reg[1] & load_prev_reg;
wire resume_low = ~resume_sync_reg[1];

////////////////////////////////////////////////////////////////////////
// Serial frame

reg [23:0] in_sr_reg;
reg [23:0] out_sr_reg;
reg [4:0] bit_cnt_reg;
reg [15:0] rd_hold_reg;
reg [15:0] rdata;

wire frame_done = cs_rise & (bit_cnt_reg == `DCC_FRAME_BITS) & ~doze_active;
wire [4:0] addr = in_sr_reg[`DCC_ADDR_HI:`DCC_ADDR_LO];
wire is_read = in_sr_reg[`DCC_RD_BIT];
wire wr_en = frame_done & ~is_read;
wire [13:0] wfield = in_sr_reg[`DCC_FIELD_HI:`DCC_FIELD_LO];

always @(posedge clock or negedge nrst)
begin
  if (!nrst)
  begin
    in_sr_reg <= 24'h000000;
    out_sr_reg <= 24'h000000;
    bit_cnt_reg <= 5'h00;
    rd_hold_reg <= 16'h0000;
    sdo <= 1'b0;
    sdo_oe <= 1'b0;
  end
  else
  begin
    sdo_oe <= cs_low | doze_active;
    if (doze_active)
    begin
      // Shift register stays frozen so the chain passes through
      sdo <= sdi_sync_reg[1];
    end
    else
    begin
      if (cs_fall)
      begin
        bit_cnt_reg <= 5'h00;
        out_sr_reg <= {8'h00, rd_hold_reg};
        sdo <= 1'b0;
      end
      else if (cs_low & sclk_rise)
      begin
        in_sr_reg <= {in_sr_reg[22:0], sdi_sync_reg[1]};
        if (bit_cnt_reg != 5'h1f)
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
      else if (cs_low & sclk_fall)
      begin
        sdo <= out_sr_reg[23];
        out_sr_reg <= {out_sr_reg[22:0], 1'b0};
      end
      if (frame_done & is_read)
        rd_hold_reg <= rdata;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Doze control

always @(posedge clock or negedge nrst)
begin
  if (!nrst)
    doze_active <= 1'b0;
  else if (resume_low)
    doze_active <= 1'b0;
  else if (wr_en & (addr == `DCC_ADDR_DOZE))
    doze_active <= in_sr_reg[`DCC_DOZE_BIT];
end

////////////////////////////////////////////////////////////////////////
// Offset codes

reg init_done_reg;
reg gain_a_prev_reg;
reg gain_b_prev_reg;
wire [13:0] trim_a = gain_sel_a ? TRIM_A_G4 : TRIM_A_G6;
wire [13:0] trim_b = gain_sel_b ? TRIM_B_G4 : TRIM_B_G6;

// Trims are loaded after reset release since reset takes only constants
always @(posedge clock or negedge nrst)
begin
  if (!nrst)
  begin
    init_done_reg <= 1'b0;
    gain_a_prev_reg <= 1'b0;
    gain_b_prev_reg <= 1'b0;
    offset_a_code <= `DCC_RST_OFS;
    offset_b_code <= `DCC_RST_OFS;
  end
  else
  begin
    init_done_reg <= 1'b1;
    gain_a_prev_reg <= gain_sel_a;
    gain_b_prev_reg <= gain_sel_b;
    if (!dual_supply)
    begin
      offset_a_code <= `DCC_RST_OFS;
      offset_b_code <= `DCC_RST_OFS;
    end
    else
    begin
      if (!init_done_reg | (gain_sel_a != gain_a_prev_reg))
        offset_a_code <= trim_a;
      else if (wr_en & (addr == `DCC_ADDR_OFS_A))
        offset_a_code <= wfield;
      if (!init_done_reg | (gain_sel_b != gain_b_prev_reg))
        offset_b_code <= trim_b;
      else if (wr_en & (addr == `DCC_ADDR_OFS_B))
        offset_b_code <= wfield;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Channel registers and correction engine

reg [13:0] in_code [0:NCH-1];
reg [13:0] data_code [0:NCH-1];
reg [13:0] zero_trim [0:NCH-1];
reg [13:0] gain_trim [0:NCH-1];

wire [14*NCH-1:0] eng_bus;
integer i;
integer j;

wire bcast_wr = wr_en & (addr == `DCC_ADDR_BCAST) & ~correction_engine_enable;
wire wr_in = wr_en & (addr[4:3] == `DCC_ADDR_GRP_INPUT);
wire wr_zero = wr_en & (addr[4:3] == `DCC_ADDR_GRP_ZERO);
wire wr_gain = wr_en & (addr[4:3] == `DCC_ADDR_GRP_GAIN);

genvar ch;
generate
  for (ch = 0; ch < NCH; ch = ch + 1)
  begin : g_ch
    // Coefficient is (gain + 2000h) / 4000h, 0.5 to just under 1.5
    wire [14:0] coef = {1'b0, gain_trim[ch]} + `DCC_GAIN_HALF;
    wire [28:0] prod = in_code[ch] * coef;
    wire [14:0] scaled = prod[28:`DCC_GAIN_SHIFT];
    wire signed [16:0] sum = $signed({2'b00, scaled}) +
      $signed({{3{zero_trim[ch][13]}}, zero_trim[ch]});
    // Headroom of 17 bits keeps the sign bit honest, no wrap
    assign eng_bus[14*ch +: 14] = sum[16] ? 14'h0000 :
      ((sum[15:14] != 2'b00) ? `DCC_CODE_MAX : sum[13:0]);
  end
endgenerate

// One process owns all channel registers, so each has a single driver
always @(posedge clock or negedge nrst)
begin
  if (!nrst)
  begin
    for (i = 0; i < NCH; i = i + 1)
    begin
      in_code[i] <= `DCC_RST_INPUT;
      data_code[i] <= `DCC_RST_INPUT;
      zero_trim[i] <= `DCC_RST_ZERO;
      gain_trim[i] <= `DCC_RST_GAIN;
    end
  end
  else
  begin
    for (i = 0; i < NCH; i = i + 1)
    begin
      if (wr_in & (addr[2:0] == i[2:0]) & correction_engine_enable)
        in_code[i] <= wfield;
      // Engine rewrites the data register each clock, one cycle behind
      if (correction_engine_enable)
        data_code[i] <= eng_bus[14*i +: 14];
      else if (bcast_wr)
        data_code[i] <= wfield;
      else if (wr_in & (addr[2:0] == i[2:0]))
        data_code[i] <= wfield;
      if (wr_zero & (addr[2:0] == i[2:0]))
        zero_trim[i] <= wfield;
      if (wr_gain & (addr[2:0] == i[2:0]))
        gain_trim[i] <= wfield;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// DAC latches

// Outputs move only on the load strobe, never on a register write
always @(posedge clock or negedge nrst)
begin
  if (!nrst)
    dac_latch_codes <= {NCH{`DCC_RST_INPUT}};
  else if (load_fall)
  begin
    for (j = 0; j < NCH; j = j + 1)
      dac_latch_codes[14*j +: 14] <= data_code[j];
  end
end

////////////////////////////////////////////////////////////////////////
// Read data

always @*
begin
  rdata = 16'h0000;
  case (addr[4:3])
    2'h0:
    begin
      if ((addr == `DCC_ADDR_OFS_A) & dual_supply)
        rdata = {offset_a_code, 2'b00};
      else if ((addr == `DCC_ADDR_OFS_B) & dual_supply)
        rdata = {offset_b_code, 2'b00};
      else if (addr == `DCC_ADDR_DOZE)
        rdata = {doze_active, 15'h0000};
      else
        rdata = 16'h0000;
    end
    `DCC_ADDR_GRP_INPUT:
      rdata = correction_engine_enable ? {in_code[addr[2:0]], 2'b00} :
        {data_code[addr[2:0]], 2'b00};
    `DCC_ADDR_GRP_ZERO:
      rdata = {zero_trim[addr[2:0]], 2'b00};
    `DCC_ADDR_GRP_GAIN:
      rdata = {gain_trim[addr[2:0]], 2'b00};
    default:
      rdata = 16'h0000;
  endcase
end

endmodule
`default_nettype wire

// [test/dcc_checker.sv]
// Port assertions for the calibration register bank
`timescale 1ns/1ns
`default_nettype none
module dcc_checker #(
  parameter NCH = 8,
  parameter [13:0] TRIM_A_G6 = 14'h0,
  parameter [13:0] TRIM_A_G4 = 14'h0,
  parameter [13:0] TRIM_B_G6 = 14'h0,
  parameter [13:0] TRIM_B_G4 = 14'h0
) (
  input wire clock,
  input wire nrst,
  input wire sclk,
  input wire cs_n,
  input wire sdo,
  input wire sdo_oe,
  input wire resume_pin_n,
  input wire latch_load_n,
  input wire gain_sel_a,
  input wire gain_sel_b,
  input wire dual_supply,
  input wire doze_active,
  input wire [13:0] offset_a_code,
  input wire [13:0] offset_b_code,
  input wire [14*NCH-1:0] dac_latch_codes
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////
  // Short windows leave room for the pin synchronisers
  a_single_zero: assert property ((!dual_supply)[*2] |-> offset_a_code == 14'h0 && offset_b_code == 14'h0)
    else $error("offset not zero");
  a_reload_grp_a: assert property (dual_supply && $changed(gain_sel_a) ##1 dual_supply && $stable(gain_sel_a)
    |-> ##[0:1] offset_a_code == (gain_sel_a ? TRIM_A_G4 : TRIM_A_G6)) else $error("group a not reloaded");
  a_reload_grp_b: assert property (dual_supply && $changed(gain_sel_b) ##1 dual_supply && $stable(gain_sel_b)
    |-> ##[0:1] offset_b_code == (gain_sel_b ? TRIM_B_G4 : TRIM_B_G6)) else $error("group b not reloaded");
  a_resume_clear: assert property ((!resume_pin_n)[*4] |-> !doze_active) else $error("doze not cleared");
  a_doze_drive: assert property (doze_active[*4] |-> sdo_oe) else $error("sdo not driven in doze");
  a_idle_quiet: assert property ((cs_n && !doze_active)[*4] |-> !sdo_oe) else $error("sdo driven idle");
  a_latch_only: assert property ($changed(dac_latch_codes) |-> !$past(latch_load_n, 2)
    || !$past(latch_load_n, 3)) else $error("latch moved without load");
  a_sdo_steady: assert property (!doze_active && !cs_n && $rose(sclk) ##1 (!cs_n && sclk)[*2]
    |-> $stable(sdo)) else $error("sdo moved while clock high");
  c_doze: cover property ($rose(doze_active));
  c_gain: cover property (dual_supply && $changed(gain_sel_a));
  c_load: cover property ($fell(latch_load_n));
endmodule
bind dcc_regs dcc_checker #(.NCH(NCH), .TRIM_A_G6(TRIM_A_G6), .TRIM_A_G4(TRIM_A_G4), .TRIM_B_G6(TRIM_B_G6),
  .TRIM_B_G4(TRIM_B_G4)) chk_u (.clock(clock), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe),
  .resume_pin_n(resume_pin_n), .latch_load_n(latch_load_n), .gain_sel_a(gain_sel_a), .gain_sel_b(gain_sel_b),
  .dual_supply(dual_supply), .doze_active(doze_active), .offset_a_code(offset_a_code),
  .offset_b_code(offset_b_code), .dac_latch_codes(dac_latch_codes));
`default_nettype wire

// [test/dcc_host.sv]
// Serial host model framing words into the register bank
`timescale 1ns/1ns
`default_nettype none
module dcc_host (
  input wire clock,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire sdo
);
  // Clock idles high and stands still between frames
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  ////////////////////
  task automatic xfer(input logic [23:0] f, output logic [23:0] q);
    @(negedge clock) cs_n = 1'b0;
    repeat (4) @(negedge clock);
    for (int i = 23; i >= 0; i--)
    begin
      sclk = 1'b0;
      sdi = f[i];
      repeat (4) @(negedge clock);
      sclk = 1'b1;
      q[i] = sdo;
      repeat (4) @(negedge clock);
    end
    cs_n = 1'b1;
    // Flipped so a stale bit never passes for data
    sdi = ~sdi;
    repeat (6) @(negedge clock);
  endtask
  task automatic pass(input logic b);
    sdi = b;
    repeat (4) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// [test/dcc_regs_bench.sv]
// Self-checking bench for the calibration register bank
`timescale 1ns/1ns
`default_nettype none
module dcc_regs_bench;
  logic clock = 1'b0, nrst = 1'b0, rsm_n = 1'b1, ld_n = 1'b1, eng = 1'b0, ga = 1'b0, gb = 1'b0, dual = 1'b1;
  wire sclk, cs_n, sdi, sdo, sdo_oe, doze;
  wire [13:0] ofa, ofb;
  wire [111:0] lat;
  logic [23:0] r;
  logic [31:0] lfsr = 32'h0001383b;
  integer n_mismatch = 0, n_checks = 0;
  integer dd [8] = '{8{0}}, lm [8] = '{8{0}};
  always #20 clock = ~clock;
  dcc_host host_u (.clock(clock), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  dcc_regs #(.TRIM_B_G6(14'h2665), .TRIM_B_G4(14'h2aa9)) dut_u (.clock(clock), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .resume_pin_n(rsm_n), .latch_load_n(ld_n),
    .correction_engine_enable(eng), .gain_sel_a(ga), .gain_sel_b(gb), .dual_supply(dual), .doze_active(doze),
    .offset_a_code(ofa), .offset_b_code(ofb), .dac_latch_codes(lat));
  ////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic integer eng_out(input integer i, input integer g, input integer z);
    integer s;
    s = ((i * (g + 16'h2000)) >> 14) + ((z >= 16'h2000) ? z - 16'h4000 : z);
    return (s < 0) ? 0 : (s > 16'h3fff) ? 16'h3fff : s;
  endfunction
  task automatic chk(input logic [15:0] seen, input integer e);
    n_checks++;
    if (seen !== e[15:0])
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, e[15:0]);
    end
  endtask
  task automatic wr(input integer a, input integer d);
    host_u.xfer({3'h0, a[4:0], d[15:0]}, r);
  endtask
  task automatic rdc(input integer a, input integer e);
    host_u.xfer({3'h4, a[4:0], 16'h0000}, r);
    host_u.xfer(24'h000000, r);
    chk(r[15:0], e);
  endtask
  task automatic load();
    @(negedge clock) ld_n = 1'b0;
    repeat (3) @(negedge clock);
    ld_n = 1'b1;
    repeat (6) @(negedge clock);
    lm = dd;
  endtask
  task automatic chkl();
    for (int c = 0; c < 8; c++)
      chk({2'h0, lat[14*c +: 14]}, lm[c]);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////
  initial
  begin
    #2000000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    logic [31:0] v;
    integer g, z, x;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    chk({2'h0, ofa}, 16'h2666);
    chk({2'h0, ofb}, 16'h2665);
    ga = 1'b1;
    gb = 1'b1;
    repeat (4) @(negedge clock);
    chk({2'h0, ofa}, 16'h2aab);
    chk({2'h0, ofb}, 16'h2aa9);
    for (int c = 0; c < 8; c++)
    begin
      rdc(8 + c, 0);
      rdc(16 + c, 0);
      rdc(24 + c, 16'h8000);
    end
    v = rnd();
    wr(4, v[15:0]);
    rdc(4, v[15:0] & 16'hfffc);
    chk({2'h0, ofa}, v[15:2]);
    @(negedge clock) dual = 1'b0;
    wr(5, v[31:16]);
    rdc(5, 0);
    chk({2'h0, ofb}, 0);
    @(negedge clock) dual = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      v = rnd();
      wr(8 + c, v[15:0]);
      dd[c] = v[15:2];
    end
    chkl();
    rdc(11, dd[3] * 4);
    load();
    chkl();
    v = rnd();
    wr(7, v[15:0]);
    rdc(7, 0);
    for (int c = 0; c < 8; c++)
      dd[c] = v[15:2];
    load();
    chkl();
    @(negedge clock) eng = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      v = rnd();
      g = (c == 1) ? 16'h3fff : v[13:0];
      z = (c == 1) ? 0 : (c == 2) ? 16'h2000 : v[27:14];
      x = (c == 1) ? 16'h3fff : (c == 2) ? 16'h0100 : v[29:16];
      wr(24 + c, g * 4 + v[31:30]);
      wr(16 + c, z * 4);
      wr(8 + c, x * 4 + v[1:0]);
      dd[c] = eng_out(x, g, z);
    end
    wr(7, v[15:0]);
    rdc(15, x * 4);
    load();
    chkl();
    @(negedge clock) eng = 1'b0;
    wr(6, 16'h8000);
    chk({15'h0, doze}, 1);
    for (int k = 0; k < 6; k++)
    begin
      v = rnd();
      host_u.pass(v[0]);
      chk({15'h0, sdo}, v[0]);
    end
    @(negedge clock) rsm_n = 1'b0;
    repeat (4) @(negedge clock);
    chk({15'h0, doze}, 0);
    rsm_n = 1'b1;
    wr(6, 16'h8000);
    chk({15'h0, doze}, 1);
    // A second reset mid-run must restore doze, offsets, input codes and channel 5 trims
    @(negedge clock) nrst = 1'b0;
    eng = 1'b1;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    chk({15'h0, doze}, 0);
    chk({2'h0, ofa}, 16'h2aab);
    chk({2'h0, ofb}, 16'h2aa9);
    for (int c = 0; c < 8; c++)
      rdc(8 + c, 0);
    rdc(21, 0);
    rdc(29, 16'h8000);
    complete_run();
  end
endmodule
`default_nettype wire
